/* rtl/ffp_pkg.sv */
// How it works
// - Rising option triggers on clock rising_edge_option
// - Falling option triggers on clock falling_edge_option
// - Outputs change only at the triggering moment
// - Set and clear both high toggles outputs
// - Other combinations behave as set-reset flop
// - Data flop loads data input when triggered
// - Set-clear flop inputs: set, clear, clock
// - Data flop inputs: data, then clock
package ffp_pkg;

  // Trigger edge choice for each flop
  typedef enum logic [1:0] {
    FFP_RISING_EDGE_OPTION  = 2'b01,
    FFP_FALLING_EDGE_OPTION = 2'b10
  } ffp_edge_t;

  // Synchroniser depth and the warm-up count that follows reset
  localparam int unsigned FFP_SYNC_STAGES = 2;
  localparam logic [1:0]  FFP_WARM_DONE   = 2'h2;
  localparam logic [1:0]  FFP_WARM_STEP   = 2'h1;
  localparam logic [1:0]  FFP_WARM_RESET  = 2'h0;

  // Reset values
  localparam logic FFP_Q_RESET    = 1'h0;
  localparam logic FFP_QN_RESET   = 1'h1;
  localparam logic FFP_SYNC_RESET = 1'h0;

  // Bit positions in the synchronised input vector
  localparam int unsigned FFP_IN_WIDTH  = 5;
  localparam int unsigned FFP_IN_SET    = 0;
  localparam int unsigned FFP_IN_CLEAR  = 1;
  localparam int unsigned FFP_IN_JKCLK  = 2;
  localparam int unsigned FFP_IN_DATA   = 3;
  localparam int unsigned FFP_IN_DCLK   = 4;

endpackage

/* rtl/ffp_sync.sv */
`timescale 1ns/10ps
module ffp_sync
  import ffp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ffp_sync_st_t;

  ffp_sync_st_t st_q;
  ffp_sync_st_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d        = st_q;
    st_d.first  = async_in;
    st_d.second = st_q.first;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{first: {WIDTH{FFP_SYNC_RESET}}, second: {WIDTH{FFP_SYNC_RESET}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.second;

endmodule

/* rtl/ffp_flops.sv */
`timescale 1ns/10ps
module ffp_flops
#(
  parameter ffp_pkg::ffp_edge_t SC_EDGE   = ffp_pkg::FFP_RISING_EDGE_OPTION,
  parameter ffp_pkg::ffp_edge_t DATA_EDGE = ffp_pkg::FFP_RISING_EDGE_OPTION
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sc_set,
  input  wire logic sc_clear,
  input  wire logic sc_clock,
  input  wire logic data_in,
  input  wire logic data_clock,
  output logic      sc_q,
  output logic      sc_q_n,
  output logic      data_q,
  output logic      data_q_n
);
  import ffp_pkg::*;

  // Action of the set-clear flop in one cycle; hold also covers no trigger
  typedef enum logic [3:0] {
    FFP_SC_HOLD   = 4'b0001,
    FFP_SC_SET    = 4'b0010,
    FFP_SC_CLEAR  = 4'b0100,
    FFP_SC_TOGGLE = 4'b1000
  } ffp_sc_act_t;

  // Action of the data flop in one cycle
  typedef enum logic [1:0] {
    FFP_DATA_HOLD = 2'b01,
    FFP_DATA_LOAD = 2'b10
  } ffp_data_act_t;

  // Stored part of one flop: last clock sample and both outputs
  typedef struct packed {
    logic clk_prev;
    logic q;
    logic q_n;
  } ffp_flop_t;

  // Whole state of the module outside the synchroniser, registered as one word
  typedef struct packed {
    logic [1:0] warm;
    ffp_flop_t  sc;
    ffp_flop_t  data;
  } ffp_state_t;

  localparam ffp_flop_t FFP_FLOP_RESET = '{
    clk_prev: FFP_SYNC_RESET,
    q:        FFP_Q_RESET,
    q_n:      FFP_QN_RESET
  };

  localparam ffp_state_t FFP_STATE_RESET = '{
    warm: FFP_WARM_RESET,
    sc:   FFP_FLOP_RESET,
    data: FFP_FLOP_RESET
  };

  // Slot of each flop in the per-flop edge vectors
  localparam int unsigned FFP_FLOP_SC    = 0;
  localparam int unsigned FFP_FLOP_DATA  = 1;
  localparam int unsigned FFP_FLOP_COUNT = 2;

  localparam ffp_edge_t FFP_EDGE_SEL [FFP_FLOP_COUNT] = '{SC_EDGE, DATA_EDGE};

  // Synchronised pins, edge detection and the decoded action of each flop
  ffp_state_t                         st_q;
  ffp_state_t                         st_d;
  logic          [FFP_IN_WIDTH-1:0]   pins;
  logic          [FFP_IN_WIDTH-1:0]   syn;
  logic                               set_s;
  logic                               clear_s;
  logic                               sc_clk_s;
  logic                               data_s;
  logic                               data_clk_s;
  logic          [FFP_FLOP_COUNT-1:0] clk_s;
  logic          [FFP_FLOP_COUNT-1:0] clk_prev;
  logic          [FFP_FLOP_COUNT-1:0] rise;
  logic          [FFP_FLOP_COUNT-1:0] fall;
  logic          [FFP_FLOP_COUNT-1:0] trig;
  logic                               warm_ok;
  logic                               sc_trig;
  logic                               data_trig;
  ffp_sc_act_t                        sc_act;
  ffp_data_act_t                      data_act;

  // Input order per flop: set, clear, clock; then data, clock
  assign pins = {data_clock, data_in, sc_clock, sc_clear, sc_set};

  ffp_sync #(
    .WIDTH (FFP_IN_WIDTH)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (pins),
    .sync_out (syn)
  );

  // Each synchronised pin under the name of its role
  assign set_s      = syn[FFP_IN_SET];
  assign clear_s    = syn[FFP_IN_CLEAR];
  assign sc_clk_s   = syn[FFP_IN_JKCLK];
  assign data_s     = syn[FFP_IN_DATA];
  assign data_clk_s = syn[FFP_IN_DCLK];
  assign clk_s      = {data_clk_s, sc_clk_s};
  assign clk_prev   = {st_q.data.clk_prev, st_q.sc.clk_prev};

  function automatic logic edge_pick(ffp_edge_t sel, logic rise_in, logic fall_in);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      FFP_RISING_EDGE_OPTION:  hit = rise_in;
      FFP_FALLING_EDGE_OPTION: hit = fall_in;
      default:                 hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Both inputs high toggles; other pairs act as a plain set-reset flop
  function automatic ffp_sc_act_t sc_decode(logic trig_in, logic set_in, logic clear_in);
    ffp_sc_act_t act;
    act = FFP_SC_HOLD;
    if (trig_in) begin
      unique case ({set_in, clear_in})
        2'b11: act = FFP_SC_TOGGLE;
        2'b10: act = FFP_SC_SET;
        2'b01: act = FFP_SC_CLEAR;
        2'b00: act = FFP_SC_HOLD;
      endcase
    end
    return act;
  endfunction

  function automatic ffp_data_act_t data_decode(logic trig_in);
    ffp_data_act_t act;
    act = FFP_DATA_HOLD;
    if (trig_in) begin
      act = FFP_DATA_LOAD;
    end
    return act;
  endfunction

  // A clock pin already high at reset release still looks like a rising edge:
  // edges count once the synchroniser has refilled, a cycle before clk_prev has
  assign warm_ok = (st_q.warm == FFP_WARM_DONE);

  // Both transitions of each clock pin against its sample one cycle earlier
  for (genvar k = 0; k < FFP_FLOP_COUNT; k++) begin : g_edge
    assign rise[k] = !clk_prev[k] && clk_s[k];
    assign fall[k] = clk_prev[k] && !clk_s[k];
    assign trig[k] = warm_ok && edge_pick(FFP_EDGE_SEL[k], rise[k], fall[k]);
  end

  assign sc_trig   = trig[FFP_FLOP_SC];
  assign data_trig = trig[FFP_FLOP_DATA];
  assign sc_act    = sc_decode(sc_trig, set_s, clear_s);
  assign data_act  = data_decode(data_trig);

  always_comb begin
    st_d               = st_q;
    st_d.sc.clk_prev   = sc_clk_s;
    st_d.data.clk_prev = data_clk_s;
    // Warm-up steps until the edge detectors are armed, then stays
    if (!warm_ok) begin
      st_d.warm = st_q.warm + FFP_WARM_STEP;
    end
    // Outputs move only on a trigger; hold covers every other cycle
    unique case (sc_act)
      FFP_SC_TOGGLE: begin
        st_d.sc.q   = !st_q.sc.q;
        st_d.sc.q_n = st_q.sc.q;
      end
      FFP_SC_SET: begin
        st_d.sc.q   = 1'b1;
        st_d.sc.q_n = 1'b0;
      end
      FFP_SC_CLEAR: begin
        st_d.sc.q   = 1'b0;
        st_d.sc.q_n = 1'b1;
      end
      FFP_SC_HOLD: begin
        st_d.sc.q   = st_q.sc.q;
        st_d.sc.q_n = st_q.sc.q_n;
      end
      default: begin
        st_d.sc.q   = st_q.sc.q;
        st_d.sc.q_n = st_q.sc.q_n;
      end
    endcase
    unique case (data_act)
      FFP_DATA_LOAD: begin
        st_d.data.q   = data_s;
        st_d.data.q_n = !data_s;
      end
      FFP_DATA_HOLD: begin
        st_d.data.q   = st_q.data.q;
        st_d.data.q_n = st_q.data.q_n;
      end
      default: begin
        st_d.data.q   = st_q.data.q;
        st_d.data.q_n = st_q.data.q_n;
      end
    endcase
  end

  // Asynchronous reset loads constants only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= FFP_STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from a register
  assign sc_q     = st_q.sc.q;
  assign sc_q_n   = st_q.sc.q_n;
  assign data_q   = st_q.data.q;
  assign data_q_n = st_q.data.q_n;

endmodule

/* verif/ffp_flops_chk.sv */
`timescale 1ns/10ps
module ffp_flops_chk
  import ffp_pkg::*;
#(
  parameter ffp_edge_t SC_EDGE   = FFP_RISING_EDGE_OPTION,
  parameter ffp_edge_t DATA_EDGE = FFP_RISING_EDGE_OPTION
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sc_set,
  input wire logic sc_clear,
  input wire logic sc_clock,
  input wire logic data_in,
  input wire logic data_clock,
  input wire logic sc_q,
  input wire logic sc_q_n,
  input wire logic data_q,
  input wire logic data_q_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam logic SR = SC_EDGE[0];
  localparam logic DR = DATA_EDGE[0];
  a_sc_set:
  assert property ($changed(sc_clock) && sc_clock == SR && sc_set && !sc_clear |-> ##3 sc_q)
    else $error("sc set missed");
  a_sc_clear:
  assert property ($changed(sc_clock) && sc_clock == SR && !sc_set && sc_clear |-> ##3 !sc_q)
    else $error("sc clear missed");
  a_sc_toggle:
  assert property ($changed(sc_clock) && sc_clock == SR && sc_set && sc_clear
    |-> ##3 sc_q != $past(sc_q)) else $error("sc toggle missed");
  a_sc_hold:
  assert property ($changed(sc_clock) && sc_clock == SR && !sc_set && !sc_clear
    |-> ##3 $stable(sc_q)) else $error("sc hold broken");
  a_sc_quiet:
  assert property (!($changed(sc_clock) && sc_clock == SR) |-> ##3 $stable(sc_q))
    else $error("sc changed untriggered");
  a_data_load:
  assert property ($changed(data_clock) && data_clock == DR |-> ##3 data_q == $past(data_in, 3))
    else $error("data load missed");
  a_data_quiet:
  assert property (!($changed(data_clock) && data_clock == DR) |-> ##3 $stable(data_q))
    else $error("data changed untriggered");
  a_comp_inverse:
  assert property (sc_q_n != sc_q && data_q_n != data_q) else $error("complement wrong");
endmodule

bind ffp_flops ffp_flops_chk #(.SC_EDGE(SC_EDGE), .DATA_EDGE(DATA_EDGE)) u_ffp_flops_chk (
  .clk, .rstn, .sc_set, .sc_clear, .sc_clock, .data_in, .data_clock,
  .sc_q, .sc_q_n, .data_q, .data_q_n);

/* verif/ffp_env.sv */
`timescale 1ns/10ps
module ffp_env (
  input  wire logic clk,
  output logic      sc_set,
  output logic      sc_clear,
  output logic      sc_clock,
  output logic      data_in,
  output logic      data_clock
);
  initial {sc_set, sc_clear, sc_clock, data_in, data_clock} = 5'h0;
  // Inputs settle two cycles before the clock pins move and stay put after
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    {sc_set, sc_clear, data_in} <= v;
    repeat (2) @(posedge clk);
    {sc_clock, data_clock} <= 2'h3;
    repeat (3) @(posedge clk);
    {sc_clock, data_clock} <= 2'h0;
    repeat (5) @(posedge clk);
  endtask
endmodule

/* verif/ffp_flops_test.sv */
`timescale 1ns/10ps
module ffp_flops_test;
  import ffp_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  wire logic  sc_set, sc_clear, sc_clock, data_in, data_clock;
  wire logic  sc_q, sc_q_n, data_q, data_q_n;
  logic [3:0] exp_q[$];
  int         mismatches = 0;
  int         checks_done = 0;
  event       seen;
  always #2 clk = ~clk;
  ffp_env u_ffp_env (.clk, .sc_set, .sc_clear, .sc_clock, .data_in, .data_clock);
  ffp_flops #(.SC_EDGE(FFP_RISING_EDGE_OPTION), .DATA_EDGE(FFP_FALLING_EDGE_OPTION)) u_ffp_flops (
    .clk, .rstn, .sc_set, .sc_clear, .sc_clock, .data_in, .data_clock,
    .sc_q, .sc_q_n, .data_q, .data_q_n);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_out(input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] outputs expected %h seen %h", e, g);
    end
  endtask
  always @(seen)
    cmp_out(exp_q.pop_front(), {sc_q, sc_q_n, data_q, data_q_n});
  initial begin
    #4000;
    mismatches++;
    give_verdict();
  end
  initial begin
    logic       es;
    logic [2:0] v;
    es = 1'b0;
    void'($urandom(32'h8906));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    // First eight passes walk every set, clear and data combination
    for (int i = 0; i < 40; i++) begin
      v = (i < 8) ? 3'(i) : 3'($urandom());
      es = (v[2] & v[1]) ? ~es : v[2] ? 1'b1 : v[1] ? 1'b0 : es;
      exp_q.push_back({es, ~es, v[0], ~v[0]});
      u_ffp_env.pulse(v);
      ->seen;
    end
    // Let the watcher take the last note before the run ends
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule
